// File: hw/aofc_output_format.sv
// Output format control: APB registers and the sample formatting path
// Assumes APB master on mclk, samples and flags synchronous to mclk
//
// The APB register port is this design's own decision.
`include "aofc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module aofc_output_format
  import aofc_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [13:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sampleValid,
  input  wire aofc_pkg::aofc_sample_t chanASample,
  input  wire aofc_pkg::aofc_sample_t chanBSample,
  input  wire logic [7:0]           overrangeIn,
  input  wire logic [1:0]           sigMonIn,
  input  wire logic [1:0]           fast_detect_flag,
  output aofc_pkg::aofc_sample_t    outSampleA,
  output aofc_pkg::aofc_sample_t    outSampleB,
  output logic [1:0]                outStatus,
  output logic                      outValid,
  output logic                      irq
);
  // Register state
  logic [7:0]  testModeQ;
  logic [7:0]  pat1LowQ;
  logic [7:0]  pat1HighQ;
  logic [7:0]  statusSelQ;
  logic [7:0]  formatQ;
  logic [7:0]  orClearQ;
  logic [7:0]  orStatusQ;
  logic [7:0]  orStatusD;
  logic [7:0]  chanSelQ;
  logic [7:0]  irqStatusQ;
  logic [7:0]  irqStatusD;
  logic [7:0]  irqMaskQ;
  logic        accessQ;
  logic        busPatRd;
  logic        patWrOk;
  logic [11:0] regIdx;
  logic        addrOk;
  logic        mapped;
  logic        isPat;
  logic [2:0]  patSlot;
  logic        wrStrobe;
  logic        rdStrobe;
  logic [7:0]  memLoData;
  logic [7:0]  memHiData;
  logic [2:0]  memRdAddr;
  logic [1:0]  patPtrQ;
  logic [1:0]  patPtrD;
  logic        patDoneQ;
  logic        userMode;
  aofc_sample_t userWord;
  aofc_sample_t rawA;
  aofc_sample_t rawB;
  aofc_sample_t fmtA;
  aofc_sample_t fmtB;
  logic [1:0]  statusBits;
  aofc_ssel_t  ssel;

  // Address decode, word index from byte address
  assign regIdx = paddr[13:2];
  assign addrOk = (paddr[1:0] == 2'h0);
  assign isPat  = (regIdx >= `AOFC_IDX_PAT1_LOW) && (regIdx <= `AOFC_IDX_PAT4_HIGH);
  assign patSlot = 3'(regIdx - `AOFC_IDX_PAT1_LOW);
  always_comb begin
    case (regIdx)
      `AOFC_IDX_TEST_MODE, `AOFC_IDX_STATUS_SEL, `AOFC_IDX_FORMAT,
      `AOFC_IDX_OR_CLEAR, `AOFC_IDX_OR_STATUS, `AOFC_IDX_CHAN_SEL,
      `AOFC_IDX_IRQ_STATUS, `AOFC_IDX_IRQ_MASK: mapped = addrOk;
      default: mapped = addrOk && isPat;
    endcase
  end

  // Access phase takes two cycles: the first registers read data, the second
  // shows pready; writes land on that answering edge, together with pready,
  // so a master that samples pready sees the write take effect there
  assign wrStrobe = psel && penable && pwrite && accessQ;
  assign rdStrobe = psel && penable && !pwrite && !accessQ;
  assign pready   = psel && penable && accessQ;
  assign pslverr  = pready && !mapped;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accessQ <= 1'b0;
    end else begin
      accessQ <= psel && penable && !accessQ;
    end
  end

  // Pattern bytes two to four live in two small memories, low and high halves,
  // so one read fetches a whole word for playout
  // A bus read of a pattern byte borrows the read port in its setup cycle; the
  // word played out in the next cycle may then be stale, so avoid such reads
  // while user pattern playout is running
  assign patWrOk   = wrStrobe && mapped && isPat && regIdx != `AOFC_IDX_PAT1_LOW
                     && regIdx != `AOFC_IDX_PAT1_HIGH;
  assign busPatRd  = psel && !penable && !pwrite && isPat;
  assign memRdAddr = busPatRd ? {1'b0, patSlot[2:1]} : {1'b0, patPtrD};

  // Low bytes, even slots
  aofc_pattern_mem uPatLoMem (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .wrEn   (patWrOk && !patSlot[0]),
    .wrAddr ({1'b0, patSlot[2:1]}),
    .wrData (pwdata[7:0]),
    .rdAddr (memRdAddr),
    .rdData (memLoData)
  );

  // High bytes, odd slots
  aofc_pattern_mem uPatHiMem (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .wrEn   (patWrOk && patSlot[0]),
    .wrAddr ({1'b0, patSlot[2:1]}),
    .wrData (pwdata[7:0]),
    .rdAddr (memRdAddr),
    .rdData (memHiData)
  );

  // Pattern one kept in flops so playout can assemble a word without port contention
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pat1LowQ  <= `AOFC_RST_ZERO;
      pat1HighQ <= `AOFC_RST_ZERO;
    end else if (wrStrobe && addrOk && regIdx == `AOFC_IDX_PAT1_LOW) begin
      pat1LowQ  <= pwdata[7:0];
    end else if (wrStrobe && addrOk && regIdx == `AOFC_IDX_PAT1_HIGH) begin
      pat1HighQ <= pwdata[7:0];
    end
  end

  // Control registers written by software
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      testModeQ  <= `AOFC_RST_ZERO;
      statusSelQ <= `AOFC_RST_ZERO;
      formatQ    <= `AOFC_RST_FORMAT;
      orClearQ   <= `AOFC_RST_ZERO;
      chanSelQ   <= `AOFC_RST_ZERO;
      irqMaskQ   <= `AOFC_RST_ZERO;
    end else if (wrStrobe && addrOk) begin
      // Unused upper bits of status select, format and channel select are stored as zero so reads show them as zero
      case (regIdx)
        `AOFC_IDX_TEST_MODE:  testModeQ  <= pwdata[7:0];
        `AOFC_IDX_STATUS_SEL: statusSelQ <= {5'h00, pwdata[2:0]};
        `AOFC_IDX_FORMAT:     formatQ    <= {5'h00, pwdata[2:0]};
        `AOFC_IDX_OR_CLEAR:   orClearQ   <= pwdata[7:0];
        `AOFC_IDX_CHAN_SEL:   chanSelQ   <= {7'h00, pwdata[0]};
        `AOFC_IDX_IRQ_MASK:   irqMaskQ   <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Per converter: sticky overrange flag, held zero while its clear bit is one,
  // and an interrupt flag set when the sticky flag goes from zero to one; set wins over write-one-clear
  genvar gc;
  generate
    for (gc = 0; gc < 8; gc++) begin : gConv
      logic orEvt;
      logic irqClr;
      assign orEvt  = sampleValid && overrangeIn[gc];
      assign irqClr = wrStrobe && addrOk && regIdx == `AOFC_IDX_IRQ_STATUS && pwdata[gc];
      assign orStatusD[gc]  = (orStatusQ[gc] || orEvt) && !orClearQ[gc];
      assign irqStatusD[gc] = (irqStatusQ[gc] && !irqClr)
                              || (orStatusD[gc] && !orStatusQ[gc]);
    end
  endgenerate

  // Overrange status register, read-only to software
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      orStatusQ <= `AOFC_RST_ZERO;
    end else begin
      orStatusQ <= orStatusD;
    end
  end

  // Interrupt flags and the level output, high while an unmasked flag is set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatusQ <= `AOFC_RST_ZERO;
      irq        <= 1'b0;
    end else begin
      irqStatusQ <= irqStatusD;
      irq        <= |(irqStatusD & irqMaskQ);
    end
  end

  // Read path: data registered on the first access cycle, shown with pready;
  // refused addresses read as zero, and prdata holds until the next read
  // Pattern bytes were fetched from the memories during the setup cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rdStrobe) begin
      if (!mapped) begin
        prdata <= 32'h0000_0000;
      end else begin
        case (regIdx)
          `AOFC_IDX_TEST_MODE:  prdata <= {24'h000000, testModeQ};
          `AOFC_IDX_PAT1_LOW:   prdata <= {24'h000000, pat1LowQ};
          `AOFC_IDX_PAT1_HIGH:  prdata <= {24'h000000, pat1HighQ};
          `AOFC_IDX_STATUS_SEL: prdata <= {24'h000000, statusSelQ};
          `AOFC_IDX_FORMAT:     prdata <= {24'h000000, formatQ};
          `AOFC_IDX_OR_CLEAR:   prdata <= {24'h000000, orClearQ};
          `AOFC_IDX_OR_STATUS:  prdata <= {24'h000000, orStatusQ};
          `AOFC_IDX_CHAN_SEL:   prdata <= {24'h000000, chanSelQ};
          `AOFC_IDX_IRQ_STATUS: prdata <= {24'h000000, irqStatusQ};
          `AOFC_IDX_IRQ_MASK:   prdata <= {24'h000000, irqMaskQ};
          // Remaining mapped indices are pattern bytes two to four
          default: prdata <= {24'h000000, patSlot[0] ? memHiData : memLoData};
        endcase
      end
    end
  end

  // User pattern playout only in test mode 1000; bit 7 picks single pass
  assign userMode = (testModeQ[3:0] == `AOFC_TM_USER);

  // Next word pointer; it also addresses the memories, so the word read at an
  // edge belongs to the pointer value that the same edge loads
  always_comb begin
    patPtrD = patPtrQ;
    if (!userMode) begin
      patPtrD = 2'h0;
    end else if (sampleValid && !patDoneQ) begin
      patPtrD = patPtrQ + 2'h1;
    end
  end

  // Word pointer, back to the first word whenever the mode is left
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      patPtrQ <= 2'h0;
    end else begin
      patPtrQ <= patPtrD;
    end
  end

  // Single pass stops after word four and sends zero until user pattern mode is left
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      patDoneQ <= 1'b0;
    end else if (!userMode) begin
      patDoneQ <= 1'b0;
    end else if (sampleValid && !patDoneQ && patPtrQ == 2'h3
                 && testModeQ[`AOFC_TM_SINGLE_BIT]) begin
      patDoneQ <= 1'b1;
    end
  end

  // Assemble the current pattern word: pattern one from flops, the others from
  // the two memories, high byte bits 5:0 on top of the low byte
  always_comb begin
    if (patPtrQ == 2'h0) begin
      userWord = {pat1HighQ[5:0], pat1LowQ};
    end else begin
      userWord = {memHiData[5:0], memLoData};
    end
  end

  // Channel selection and swap; in user mode both channels carry the pattern
  // Swap first, then format and invert, so both channels see the same treatment
  always_comb begin
    rawA = userMode ? (patDoneQ ? '0 : userWord) : chanASample;
    rawB = userMode ? (patDoneQ ? '0 : userWord) : chanBSample;
    if (chanSelQ[`AOFC_SWAP_BIT]) begin
      fmtA = rawB;
      fmtB = rawA;
    end else begin
      fmtA = rawA;
      fmtB = rawB;
    end
    // Offset binary flips the sign bit of twos complement input
    if (formatQ[1:0] == `AOFC_FMT_OFFSET_BIN) begin
      fmtA[13] = ~fmtA[13];
      fmtB[13] = ~fmtB[13];
    end
    if (formatQ[`AOFC_INV_BIT]) begin
      fmtA = ~fmtA;
      fmtB = ~fmtB;
    end
  end

  // Status bit beside the data
  assign ssel = aofc_ssel_t'(statusSelQ[2:0]);
  always_comb begin
    case (ssel)
      AOFC_SS_LOW:    statusBits = 2'h0;
      AOFC_SS_OVER:   statusBits = {|overrangeIn[7:4], |overrangeIn[3:0]};
      AOFC_SS_SIGMON: statusBits = sigMonIn;
      AOFC_SS_FAST:   statusBits = fast_detect_flag;
      AOFC_SS_NA:     statusBits = 2'h0; // Not applicable code sends low
      default:        statusBits = 2'h0;
    endcase
  end

  // Registered output stage, one cycle after the sample inputs
  // Status bits follow their channel when the channels are swapped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      outSampleA <= '0;
      outSampleB <= '0;
      outStatus  <= 2'h0;
      outValid   <= 1'b0;
    end else begin
      outSampleA <= fmtA;
      outSampleB <= fmtB;
      outStatus  <= chanSelQ[`AOFC_SWAP_BIT] ? {statusBits[0], statusBits[1]} : statusBits;
      outValid   <= sampleValid;
    end
  end
endmodule
`default_nettype wire

// File: hw/aofc_params.svh
// Register offsets, field positions, reset values for output format control
// Included by the design modules; definitions only
`ifndef AOFC_PARAMS_SVH
`define AOFC_PARAMS_SVH

// Printed offsets are not word multiples: these are indices, byte address = 4 * index
`define AOFC_IDX_TEST_MODE     12'h550
`define AOFC_IDX_PAT1_LOW      12'h551
`define AOFC_IDX_PAT1_HIGH     12'h552
`define AOFC_IDX_PAT2_LOW      12'h553
`define AOFC_IDX_PAT2_HIGH     12'h554
`define AOFC_IDX_PAT3_LOW      12'h555
`define AOFC_IDX_PAT3_HIGH     12'h556
`define AOFC_IDX_PAT4_LOW      12'h557
`define AOFC_IDX_PAT4_HIGH     12'h558
`define AOFC_IDX_STATUS_SEL    12'h559
`define AOFC_IDX_FORMAT        12'h561
`define AOFC_IDX_OR_CLEAR      12'h562
`define AOFC_IDX_OR_STATUS     12'h563
`define AOFC_IDX_CHAN_SEL      12'h564
`define AOFC_IDX_IRQ_STATUS    12'h580
`define AOFC_IDX_IRQ_MASK      12'h581

// Field positions
`define AOFC_TM_SEL_LSB        0
`define AOFC_TM_SINGLE_BIT     7
`define AOFC_SSEL_LSB          0
`define AOFC_FMT_LSB           0
`define AOFC_INV_BIT           2
`define AOFC_SWAP_BIT          0

// Codes
`define AOFC_TM_USER           4'h8
`define AOFC_FMT_OFFSET_BIN    2'h0
`define AOFC_FMT_TWOS          2'h1

// Reset values
`define AOFC_RST_ZERO          8'h00
`define AOFC_RST_FORMAT        8'h01

`endif

// File: hw/aofc_pkg.sv
// Types shared by the output format control design files
// Assumes aofc_params.svh is on the include path
package aofc_pkg;
  // Status bit carried beside the sample data
  typedef enum logic [2:0] {
    AOFC_SS_LOW      = 3'h0,
    AOFC_SS_OVER     = 3'h1,
    AOFC_SS_SIGMON   = 3'h2,
    AOFC_SS_FAST     = 3'h3,
    AOFC_SS_NA       = 3'h4
  } aofc_ssel_t;

  typedef logic [13:0] aofc_sample_t;
  typedef logic [7:0]  aofc_byte_t;
endpackage

// File: hw/aofc_pattern_mem.sv
// Eight-byte store for one half (low or high bytes) of the user pattern words
// Assumes one clock mclk and asynchronous active-low reset rst_n
`include "aofc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module aofc_pattern_mem
  import aofc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              wrEn,
  input  wire logic [2:0]        wrAddr,
  input  wire aofc_pkg::aofc_byte_t wrData,
  input  wire logic [2:0]        rdAddr,
  output aofc_pkg::aofc_byte_t   rdData
);
  aofc_byte_t memQ [8];

  // Byte storage, every byte resets to zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gByte
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          memQ[gi] <= `AOFC_RST_ZERO;
        end else if (wrEn && wrAddr == 3'(gi)) begin
          memQ[gi] <= wrData;
        end
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= `AOFC_RST_ZERO;
    end else begin
      rdData <= memQ[rdAddr];
    end
  end
endmodule
`default_nettype wire

// File: testbench/aofc_output_format_chk.sv
// Port checker for the output format control block
// Bound to aofc_output_format; one clock mclk, reset rst_n
`timescale 1ns/10ps
`default_nettype none
module aofc_output_format_chk (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sampleValid,
  input wire logic        outValid,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Bus answer timing
  chk_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  chk_ready_idle: assert property (!(psel && penable) |-> !pready && !pslverr)
    else $error("answer outside access");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_rdata_width: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // Sample path and interrupt
  chk_valid_lat: assert property (1'b1 |=> outValid == $past(sampleValid))
    else $error("valid latency wrong");
  chk_irq_hold: assert property (irq && !(psel && penable && pwrite) |=> irq)
    else $error("interrupt dropped without write");
  cov_read_err: cover property (pready && pslverr && !pwrite);
  cov_sample: cover property (sampleValid ##1 outValid);
  cov_irq: cover property ($rose(irq));
endmodule
bind aofc_output_format aofc_output_format_chk u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sampleValid(sampleValid), .outValid(outValid), .irq(irq));
`default_nettype wire

// File: testbench/test_aofc_output_format.sv
// Self-checking bench for the output format control block
// Drives APB and sample ports itself; expectations kept in queues
`timescale 1ns/10ps
`default_nettype none
module test_aofc_output_format;
  import aofc_pkg::*;
  logic         mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic         sampleValid, outValid, irq, inv, swp, e;
  logic [13:0]  paddr;
  logic [31:0]  pwdata, prdata, seed, r;
  aofc_sample_t chanASample, chanBSample, outSampleA, outSampleB, xa, xb;
  logic [7:0]   overrangeIn;
  logic [1:0]   sigMonIn, fastDet, outStatus, fmt, st;
  logic [2:0]   ssel;
  logic [7:0]   pb[8];
  logic [13:0]  pw;
  logic [32:0]  rdQ[$];
  logic [29:0]  smpQ[$];
  int           miscompares, checksDone, i, k;
  logic [11:0]  ix[11] = '{12'h553, 12'h554, 12'h555, 12'h556, 12'h557, 12'h558,
                          12'h559, 12'h561, 12'h562, 12'h563, 12'h564};
  aofc_output_format u_aofc_output_format (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sampleValid(sampleValid), .chanASample(chanASample),
    .chanBSample(chanBSample), .overrangeIn(overrangeIn), .sigMonIn(sigMonIn),
    .fast_detect_flag(fastDet), .outSampleA(outSampleA), .outSampleB(outSampleB),
    .outStatus(outStatus), .outValid(outValid), .irq(irq));
  // Clock
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d miscompares=%0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
    psel <= 0;
    penable <= 0;
    // Idle edge so the next call never reassigns psel in this time step
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic er);
    rdQ.push_back({er, 24'h0, d});
    apb(0, a, 8'h00);
  endtask
  // One sample cycle, expected output noted from the bench model
  task automatic smp(input logic [7:0] ov, input logic pm = 1'b0,
                     input logic [13:0] pw = 14'h0000);
    r = rnd();
    xa = r[13:0];
    xb = r[27:14];
    chanASample <= xa;
    chanBSample <= xb;
    sigMonIn <= r[29:28];
    fastDet <= r[31:30];
    overrangeIn <= ov;
    sampleValid <= 1;
    if (pm) begin
      xa = pw;
      xb = pw;
    end
    if (fmt == 2'h0) {xa, xb} = {xa ^ 14'h2000, xb ^ 14'h2000};
    if (inv) {xa, xb} = ~{xa, xb};
    st = (ssel == 3'h2) ? r[29:28] : (ssel == 3'h3) ? r[31:30] : 2'h0;
    smpQ.push_back(swp ? {xb, xa, st} : {xa, xb, st});
    @(posedge mclk);
  endtask
  task automatic irqchk(input logic x);
    sampleValid <= 0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    cmp({32'h0, irq}, {32'h0, x});
    @(posedge mclk);
  endtask
  // Result watchers
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rdQ.size() > 0)
      cmp({pslverr, prdata}, rdQ.pop_front());
    if (outValid === 1'b1 && smpQ.size() > 0)
      cmp({3'h0, outSampleA, outSampleB, outStatus}, {3'h0, smpQ.pop_front()});
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, sampleValid} = '0;
    {chanASample, chanBSample, overrangeIn, sigMonIn, fastDet} = '0;
    seed = 81;
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    for (i = 0; i < 11; i++) rd(ix[i], (ix[i] == 12'h561) ? 8'h01 : 8'h00, 0);
    for (i = 0; i < 6; i++) begin
      r = rnd();
      apb(1, ix[i], r[7:0]);
      rd(ix[i], r[7:0], 0);
    end
    rd(12'h5A0, 8'h00, 1);
    // Both formats, invert, swap and status codes 0 to 3, back-to-back samples
    for (i = 0; i < 8; i++) begin
      {swp, inv, fmt} = {i[2], i[1], 1'b0, ~i[0]};
      ssel = swp ? 3'h0 : {1'b0, i[1:0]};
      apb(1, 12'h559, {5'h0, ssel});
      apb(1, 12'h561, {5'h0, inv, fmt});
      apb(1, 12'h564, {7'h0, swp});
      for (k = 0; k < 3; k++) smp(8'h00);
      sampleValid <= 0;
      @(posedge mclk);
    end
    // Overrange flags, clear and interrupt
    apb(1, 12'h581, 8'h01);
    smp(8'h81);
    irqchk(1);
    rd(12'h563, 8'h81, 0);
    rd(12'h580, 8'h81, 0);
    apb(1, 12'h563, 8'h00);
    rd(12'h563, 8'h81, 0);
    apb(1, 12'h562, 8'h01);
    smp(8'h01);
    irqchk(1);
    rd(12'h563, 8'h80, 0);
    rd(12'h562, 8'h01, 0);
    apb(1, 12'h562, 8'h00);
    rd(12'h563, 8'h80, 0);
    apb(1, 12'h580, 8'hFF);
    irqchk(0);
    apb(1, 12'h581, 8'h00);
    smp(8'h02);
    irqchk(0);
    rd(12'h580, 8'h02, 0);
    rd(12'h563, 8'h82, 0);
    // User pattern playout, single pass, then zero words
    {swp, inv, fmt} = {1'b0, 1'b0, 2'h1};
    apb(1, 12'h561, 8'h01);
    apb(1, 12'h564, 8'h00);
    for (i = 0; i < 8; i++) begin
      r = rnd();
      pb[i] = r[7:0];
      apb(1, 12'h551 + 12'(i), pb[i]);
    end
    rd(12'h556, pb[5], 0);
    apb(1, 12'h550, 8'h88);
    for (k = 0; k < 6; k++) begin
      pw = (k < 4) ? {pb[2 * k + 1][5:0], pb[2 * k]} : 14'h0000;
      smp(8'h00, 1'b1, pw);
    end
    sampleValid <= 0;
    @(posedge mclk);
    apb(1, 12'h550, 8'h00);
    repeat (3) @(posedge mclk);
    print_verdict();
  end
endmodule
`default_nettype wire
